// >>> usart_frame_consts.svh
`ifndef USART_FRAME_CONSTS_SVH
`define USART_FRAME_CONSTS_SVH

`define ADDR_W 4
`define OFF_CTRL_A 4'h0
`define OFF_CTRL_B 4'h4
`define OFF_STATUS 4'h8
`define OFF_TIMEOUT 4'hC
`define OFF_TXDATA 4'h0
`define CTRL_A_MASK 32'h1400_1009
`define CTRL_B_MASK 32'h00FF_BF10
`define TIMEOUT_MASK 32'h00FF_FFFF
`define RST_ZERO 32'h0000_0000
`define BIT_EN 0
`define BIT_TXEN 3
`define BIT_DLS_LO 12
`define BIT_TOIE 26
`define BIT_DLS_HI 28
`define BIT_NODE_ADDRESS_WIDTH 4
`define BIT_LASTPULSE 8
`define BIT_PHASE 9
`define BIT_IDLELVL 10
`define BIT_CKEN 11
`define BIT_STOP_LO 12
`define BIT_SWAP 15
`define BIT_RXINV 16
`define BIT_TXINV 17
`define BIT_DINV 18
`define BIT_MSBF 19
`define BIT_ABR 20
`define BIT_ABRM_LO 21
`define BIT_TODET 23
`define ST_TOFLAG 0
`define ST_TXBUSY 1
`define ST_ABRDONE 2
`define ST_ABRCNT_LO 8
`define CTRL_A_STATUS_W 4'hC
`define DIV_DEFAULT 16
`define TOUT_W 24

`endif

// >>> usart_frame_pkg.sv
package usart_frame_pkg;
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA = 5'b00100,
    TX_STOP = 5'b01000,
    TX_DONE = 5'b10000
  } tx_state_t;

  typedef enum logic [1:0] {
    LEN_8 = 2'b00,
    LEN_9 = 2'b01,
    LEN_7 = 2'b10
  } data_len_t;

  typedef enum logic [1:0] {
    ABR_START = 2'b00,
    ABR_FALL = 2'b01,
    ABR_7F = 2'b10,
    ABR_55 = 2'b11
  } abr_method_t;
endpackage

// >>> usart_rx_timeout.sv
`include "usart_frame_consts.svh"

module usart_rx_timeout #(
  parameter int TW = `TOUT_W
) (
  input wire logic clock_i, // core clock
  input wire logic rst_n_i, // synchronised reset
  input wire logic enable_i, // detection enabled
  input wire logic line_idle_i, // rx line at idle level
  input wire logic [TW-1:0] limit_i, // idle cycles until timeout
  output logic expired_o // one-cycle pulse on timeout
);
  typedef struct packed {
    logic [TW-1:0] cnt;
    logic fired;
    logic exp;
  } to_state_t;

  to_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.exp = 1'b0;
    if (!enable_i || !line_idle_i) begin
      s_d.cnt = '0;
      s_d.fired = 1'b0;
    end else if (!s_q.fired) begin
      if (s_q.cnt >= limit_i) begin
        s_d.exp = 1'b1;
        s_d.fired = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign expired_o = s_q.exp;
endmodule

// >>> usart_frame_line_config.sv
// Design decision made here: the strobed register port.
`include "usart_frame_consts.svh"

// Functional notes
// RL1 - timeout interrupt asserted while timeout flag set and its enable is one
// RL2 - data length code: 00 eight bits, 01 nine bits, 10 seven bits
// RL3 - software keeps upper length bit steady while a character transmits
// RL4 - address length bit picks four or seven bit node address width
// RL5 - synchronous mode: clock pulse for final data bit only when enabled
// RL6 - phase bit picks first or second clock edge for sampling
// RL7 - polarity bit sets idle clock pin level
// RL8 - clock output enable gates driving the serial clock pin
// RL9 - stop field: 00 one stop bit, 10 two stop bits
// RL10 - swap enable exchanges transmit and receive pin roles
// RL11 - receive line inversion flips received levels
// RL12 - transmit line inversion flips driven levels
// RL13 - data inversion sends data and parity bits in negative logic
// RL14 - bit order: zero gives lsb first, one gives msb first
// RL15 - auto rate detection measures incoming traffic for bit rate
// RL16 - method field selects start bit, falling edges, 0x7F or 0x55 frame
// RL17 - timeout detect sets flag after rx idle for programmed duration
// RL18 - software changes frame and pin settings only while disabled
// RL19 - second control register at offset 0x04 resetting to zero
// RL20 - lower length bit alone: zero eight bits, one nine bits
// RL21 - reserved bits read zero and writes to them do nothing
// RL22 - clock settings have no pin effect with clock output disabled
module usart_frame_line_config
  import usart_frame_pkg::*;
#(
  parameter int DIV = `DIV_DEFAULT,
  parameter int TW = `TOUT_W
) (
  input wire logic clock_i, // 40 MHz core clock
  input wire logic rstn_i, // async active-low reset
  input wire logic [`ADDR_W-1:0] addr_i, // register byte address
  input wire logic [31:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [31:0] rdata_o, // read data, cycle after rd_i
  input wire logic [8:0] tx_word_i, // word to send
  input wire logic tx_valid_i, // send request pulse
  output logic tx_busy_o, // frame in progress
  input wire logic pin_a_i, // pin a input level
  input wire logic pin_b_i, // pin b input level
  output logic pin_a_o, // pin a output level
  output logic pin_a_oe_o, // pin a driven
  output logic pin_b_o, // pin b output level
  output logic pin_b_oe_o, // pin b driven
  output logic serial_clock_pin_o, // clock pin level
  output logic serial_clock_pin_oe_o, // clock pin driven
  output logic node_address_width_o, // 1: seven-bit address matching
  output logic irq_o // timeout interrupt request
);
  typedef struct packed {
    logic [31:0] ctrl_a;
    logic [31:0] ctrl_b;
    logic [TW-1:0] tout;
    logic [31:0] rdata;
    logic to_flag;
    tx_state_t st;
    logic [8:0] shreg;
    logic [3:0] nbits;
    logic [3:0] bitcnt;
    logic [15:0] divcnt;
    logic half;
    logic txd;
    logic ck;
    logic ck_oe;
    logic rx_prev;
    logic abr_run;
    logic abr_done;
    logic [15:0] abr_cnt;
    logic [2:0] abr_edges;
    logic irq;
    logic addr_w;
  } core_t;

  core_t s_q, s_d;
  logic rst_m_q, rst_s_q;
  logic expired;
  logic rx_line;

  function automatic logic [3:0] data_bits(input logic [1:0] code);
    unique case (code)
      LEN_9: data_bits = 4'h9; // RL2
      LEN_7: data_bits = 4'h7; // RL2
      default: data_bits = 4'h8; // RL2 RL20
    endcase
  endfunction

  function automatic logic [8:0] reverse_bits(input logic [8:0] w, input logic [3:0] n);
    logic [8:0] r;
    r = '0;
    for (int i = 0; i < 9; i++) begin
      if (i < n) begin
        r[n - 1 - i] = w[i];
      end
    end
    return r;
  endfunction

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  // swap picks which pin receives; rx inversion applied before anything looks at it
  assign rx_line = (s_q.ctrl_b[`BIT_SWAP] ? pin_a_i : pin_b_i) ^ s_q.ctrl_b[`BIT_RXINV]; // RL10 RL11

  usart_rx_timeout #(
    .TW(TW)
  ) u_timeout (
    .clock_i(clock_i),
    .rst_n_i(rst_s_q),
    .enable_i(s_q.ctrl_b[`BIT_TODET]), // RL17
    .line_idle_i(rx_line),
    .limit_i(s_q.tout),
    .expired_o(expired)
  );

  always_comb begin
    logic sync_mode;
    logic [3:0] nb;
    logic [8:0] frame;
    logic bit_now;
    logic last_data;
    sync_mode = 1'b0;
    nb = 4'h0;
    frame = '0;
    bit_now = 1'b0;
    last_data = 1'b0;
    s_d = s_q;
    s_d.rdata = '0;
    sync_mode = s_q.ctrl_b[`BIT_CKEN];

    // register writes; reserved bits masked off
    if (wr_i) begin
      unique case (addr_i)
        `OFF_CTRL_A: s_d.ctrl_a = wdata_i & `CTRL_A_MASK; // RL21
        `OFF_CTRL_B: s_d.ctrl_b = wdata_i & `CTRL_B_MASK; // RL19 RL21
        `OFF_STATUS: begin
          // write one clears; detection in the same cycle wins
          if (wdata_i[`ST_TOFLAG]) s_d.to_flag = 1'b0;
          if (wdata_i[`ST_ABRDONE]) s_d.abr_done = 1'b0;
        end
        `OFF_TIMEOUT: s_d.tout = wdata_i[TW-1:0];
        default: ;
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        `OFF_CTRL_A: s_d.rdata = s_q.ctrl_a;
        `OFF_CTRL_B: s_d.rdata = s_q.ctrl_b; // RL19
        `OFF_STATUS: s_d.rdata = {8'h00, s_q.abr_cnt, 5'h00, s_q.abr_done, tx_busy_o, s_q.to_flag};
        `OFF_TIMEOUT: s_d.rdata = {{(32-TW){1'b0}}, s_q.tout};
        default: s_d.rdata = '0;
      endcase
    end

    if (expired) s_d.to_flag = 1'b1; // RL17
    s_d.irq = s_q.to_flag & s_q.ctrl_a[`BIT_TOIE]; // RL1
    s_d.addr_w = s_q.ctrl_b[`BIT_NODE_ADDRESS_WIDTH]; // RL4

    // auto rate: count cycles over the measured span, result in status
    s_d.rx_prev = rx_line;
    if (!s_q.ctrl_b[`BIT_ABR]) begin
      s_d.abr_run = 1'b0; // RL15
      s_d.abr_edges = '0;
    end else if (!s_q.abr_run && !s_q.abr_done) begin
      if (s_q.rx_prev && !rx_line) begin
        s_d.abr_run = 1'b1; // RL15
        s_d.abr_cnt = '0;
        s_d.abr_edges = '0;
      end
    end else if (s_q.abr_run) begin
      s_d.abr_cnt = s_q.abr_cnt + 1'b1;
      unique case (abr_method_t'(s_q.ctrl_b[`BIT_ABRM_LO +: 2]))
        ABR_START: if (!s_q.rx_prev && rx_line) begin // RL16
          s_d.abr_run = 1'b0;
          s_d.abr_done = 1'b1;
        end
        ABR_FALL: if (s_q.rx_prev && !rx_line) begin // RL16
          s_d.abr_run = 1'b0;
          s_d.abr_done = 1'b1;
        end
        ABR_7F: if (s_q.rx_prev && !rx_line) begin // RL16
          // 0x7F: start plus seven ones, next fall is after eight bits
          s_d.abr_run = 1'b0;
          s_d.abr_done = 1'b1;
        end
        ABR_55: if (s_q.rx_prev && !rx_line) begin // RL16
          s_d.abr_edges = s_q.abr_edges + 1'b1;
          if (s_q.abr_edges == 3'h3) begin
            s_d.abr_run = 1'b0;
            s_d.abr_done = 1'b1;
          end
        end
      endcase
    end

    // transmitter
    s_d.half = 1'b0;
    if (s_q.divcnt != '0) begin
      s_d.divcnt = s_q.divcnt - 1'b1;
      if (s_q.divcnt == 16'(DIV / 2)) s_d.half = 1'b1;
    end
    unique case (s_q.st)
      TX_IDLE: begin
        s_d.txd = 1'b1;
        if (tx_valid_i && s_q.ctrl_a[`BIT_EN]) begin
          nb = data_bits({s_q.ctrl_a[`BIT_DLS_HI], s_q.ctrl_a[`BIT_DLS_LO]}); // RL3
          frame = tx_word_i & ((9'h001 << nb) - 9'h001);
          if (s_q.ctrl_b[`BIT_MSBF]) frame = reverse_bits(frame, nb); // RL14
          s_d.shreg = frame;
          s_d.nbits = nb;
          s_d.st = TX_START;
          s_d.txd = 1'b0;
          s_d.divcnt = 16'(DIV - 1);
        end
      end
      TX_START: if (s_q.divcnt == '0) begin
        s_d.st = TX_DATA;
        s_d.bitcnt = '0;
        s_d.txd = s_q.shreg[0] ^ s_q.ctrl_b[`BIT_DINV]; // RL13
        s_d.divcnt = 16'(DIV - 1);
      end
      TX_DATA: if (s_q.divcnt == '0) begin
        if (s_q.bitcnt == s_q.nbits - 4'h1) begin
          s_d.st = TX_STOP;
          s_d.txd = 1'b1;
          s_d.bitcnt = '0;
        end else begin
          s_d.shreg = {1'b0, s_q.shreg[8:1]};
          s_d.bitcnt = s_q.bitcnt + 1'b1;
          s_d.txd = s_q.shreg[1] ^ s_q.ctrl_b[`BIT_DINV]; // RL13
        end
        s_d.divcnt = 16'(DIV - 1);
      end
      TX_STOP: if (s_q.divcnt == '0) begin
        // 10 gives a second stop bit; reserved codes fall back to one
        if (s_q.ctrl_b[`BIT_STOP_LO +: 2] == 2'b10 && s_q.bitcnt == '0) begin // RL9
          s_d.bitcnt = 4'h1;
          s_d.divcnt = 16'(DIV - 1);
        end else begin
          s_d.st = TX_DONE;
        end
      end
      TX_DONE: s_d.st = TX_IDLE;
      default: s_d.st = TX_IDLE;
    endcase

    // synchronous clock: one pulse per data bit, the last one only with lastpulse set, first half at idle level then active
    last_data = (s_q.st == TX_DATA) && (s_q.bitcnt == s_q.nbits - 4'h1);
    bit_now = (s_q.st == TX_DATA) && (!last_data || s_q.ctrl_b[`BIT_LASTPULSE]); // RL5
    // phase 1 shifts the pulse by half a bit so data is sampled on the second edge
    if (!bit_now) begin
      s_d.ck = s_q.ctrl_b[`BIT_IDLELVL]; // RL7
    end else if (s_q.ctrl_b[`BIT_PHASE]) begin // RL6
      s_d.ck = s_q.ctrl_b[`BIT_IDLELVL] ^ (s_q.divcnt > 16'(DIV / 2));
    end else begin
      s_d.ck = s_q.ctrl_b[`BIT_IDLELVL] ^ (s_q.divcnt <= 16'(DIV / 2)); // RL6
    end
    s_d.ck_oe = sync_mode & s_q.ctrl_a[`BIT_EN]; // RL8 RL22
  end

  always_ff @(posedge clock_i or negedge rst_s_q) begin
    if (!rst_s_q) begin
      s_q <= '0; // RL19
      s_q.st <= TX_IDLE;
      s_q.txd <= 1'b1;
      s_q.rx_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  logic tx_level;
  assign tx_level = s_q.txd ^ s_q.ctrl_b[`BIT_TXINV]; // RL12

  always_comb begin
    rdata_o = s_q.rdata;
    tx_busy_o = (s_q.st != TX_IDLE);
    pin_a_o = s_q.ctrl_b[`BIT_SWAP] ? 1'b0 : tx_level; // RL10
    pin_a_oe_o = ~s_q.ctrl_b[`BIT_SWAP] & s_q.ctrl_a[`BIT_TXEN];
    pin_b_o = s_q.ctrl_b[`BIT_SWAP] ? tx_level : 1'b0; // RL10
    pin_b_oe_o = s_q.ctrl_b[`BIT_SWAP] & s_q.ctrl_a[`BIT_TXEN];
    serial_clock_pin_o = s_q.ck_oe & s_q.ck; // RL22
    serial_clock_pin_oe_o = s_q.ck_oe; // RL8
    node_address_width_o = s_q.addr_w;
    irq_o = s_q.irq;
  end
endmodule

// >>> usart_frame_line_config_checker.sv
`include "usart_frame_consts.svh"

module usart_frame_line_config_checker (
  input wire logic clock_i, // clock
  input wire logic rstn_i, // reset
  input wire logic [`ADDR_W-1:0] addr_i, // address
  input wire logic [31:0] wdata_i, // write data
  input wire logic wr_i, // write
  input wire logic rd_i, // read
  input wire logic [31:0] rdata_o, // read data
  input wire logic tx_valid_i, // send
  input wire logic tx_busy_o, // busy
  input wire logic pin_a_oe_o, // pin a oe
  input wire logic pin_b_oe_o, // pin b oe
  input wire logic serial_clock_pin_o, // clock pin
  input wire logic serial_clock_pin_oe_o, // clock oe
  input wire logic node_address_width_o, // addr width
  input wire logic irq_o // irq
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  logic sync_clock_idle_level_q;
  // shadow of the idle level, written on every write to offset 0x04, busy or not
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) sync_clock_idle_level_q <= 1'b0;
    else if (wr_i && addr_i == 4'h4) sync_clock_idle_level_q <= wdata_i[10];
  end
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not zero outside read");
  a_ctrl_b_rsvd: assert property (rd_i && addr_i == 4'h4 |=> (rdata_o & ~32'h00FF_BF10) == 32'h0)
    else $error("reserved bit of ctrl b reads one");
  a_ctrl_a_rsvd: assert property (rd_i && addr_i == 4'h0 |=> (rdata_o & ~32'h1400_1009) == 32'h0)
    else $error("reserved bit of ctrl a reads one");
  a_clk_pin_off: assert property (!serial_clock_pin_oe_o |-> !serial_clock_pin_o)
    else $error("clock pin active while not driven");
  a_one_tx_pin: assert property (!(pin_a_oe_o && pin_b_oe_o))
    else $error("both line pins driven");
  a_busy_cause: assert property ($rose(tx_busy_o) |-> $past(tx_valid_i))
    else $error("frame started without request");
  a_irq_masked: assert property (wr_i && addr_i == 4'h0 && !wdata_i[26] |-> ##2 !irq_o)
    else $error("interrupt while disabled");
  a_addr_width: assert property (wr_i && addr_i == 4'h4 |-> ##2 node_address_width_o == $past(wdata_i[4], 2))
    else $error("address width not following register");
  a_clk_idle_lvl: assert property ((!tx_busy_o && $stable(sync_clock_idle_level_q))[*3] ##0 serial_clock_pin_oe_o &&
      $past(serial_clock_pin_oe_o, 2) |-> serial_clock_pin_o == sync_clock_idle_level_q)
    else $error("clock idle level wrong");
endmodule

bind usart_frame_line_config usart_frame_line_config_checker chk (.clock_i(clock_i), .rstn_i(rstn_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_valid_i(tx_valid_i),
  .tx_busy_o(tx_busy_o), .pin_a_oe_o(pin_a_oe_o), .pin_b_oe_o(pin_b_oe_o),
  .serial_clock_pin_o(serial_clock_pin_o), .serial_clock_pin_oe_o(serial_clock_pin_oe_o),
  .node_address_width_o(node_address_width_o), .irq_o(irq_o));

// >>> usart_remote_model.sv
module usart_remote_model #(
  parameter int DIV = 8
) (
  input wire logic clock_i, // clock
  input wire logic line_i, // wire from the block
  input wire logic idle_i, // idle level of that wire
  input wire logic [3:0] nbits_i, // bits per frame
  input wire logic rx_lvl_i, // level we drive
  output logic rx_o, // wire to the block
  output logic [12:0] bits_o, // raw samples, first bit lowest
  output logic done_o // frame captured
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev;
  int i;
  assign rx_o = rx_lvl_i;
  always @(posedge clock_i) prev <= line_i;
  // raw levels only, so inversion and order are judged by the bench
  initial begin
    done_o = 1'b0;
    bits_o = 13'h0;
    forever begin
      @(posedge clock_i);
      if (prev === idle_i && line_i === !idle_i) begin
        done_o = 1'b0;
        bits_o = 13'h0;
        repeat (DIV / 2) @(posedge clock_i);
        for (i = 0; i < nbits_i; i++) begin
          bits_o[i] = line_i;
          repeat (DIV) @(posedge clock_i);
        end
        done_o = 1'b1;
      end
    end
  end
endmodule

// >>> usart_frame_line_config_tb_top.sv
module usart_frame_line_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 8;
  logic clock_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, tx_valid_i = 0, rx_lvl = 1;
  logic [3:0] addr_i = 4'h0;
  logic [3:0] nb = 4'hA;
  logic [31:0] wdata_i = 32'h0;
  logic [31:0] rdata_o;
  logic [8:0] tx_word_i = 9'h0;
  logic [12:0] bits;
  logic tx_busy_o, pa_o, pa_oe, pb_o, pb_oe, ck_o, ck_oe, naw_o, irq_o, done, ckp;
  logic swp = 0, idle = 1, sync_clock_idle_level = 0;
  int n_errors = 0, compares = 0, pulses = 0;
  wire rx_w;
  wire wa = pa_oe ? pa_o : rx_w;
  wire wb = pb_oe ? pb_o : rx_w;

  always #12.5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    ckp <= ck_o;
    if (tx_busy_o && ckp === sync_clock_idle_level && ck_o === !sync_clock_idle_level) pulses <= pulses + 1;
  end

  usart_frame_line_config #(.DIV(DIV)) DUT (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_word_i(tx_word_i),
    .tx_valid_i(tx_valid_i), .tx_busy_o(tx_busy_o), .pin_a_i(wa), .pin_b_i(wb), .pin_a_o(pa_o),
    .pin_a_oe_o(pa_oe), .pin_b_o(pb_o), .pin_b_oe_o(pb_oe), .serial_clock_pin_o(ck_o),
    .serial_clock_pin_oe_o(ck_oe), .node_address_width_o(naw_o), .irq_o(irq_o));
  usart_remote_model #(.DIV(DIV)) peer (.clock_i(clock_i), .line_i(swp ? wb : wa), .idle_i(idle),
    .nbits_i(nb), .rx_lvl_i(rx_lvl), .rx_o(rx_w), .bits_o(bits), .done_o(done));

  task automatic stop_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    chk(rdata_o & m, e);
  endtask
  task automatic frame(input logic [31:0] cb, input logic [31:0] ca, input int nd, input logic [8:0] w,
                       input int np);
    logic [12:0] e;
    int k, st, p0;
    st = cb[13] ? 2 : 1;
    swp = cb[15];
    idle = !cb[17];
    // released line rests at the same level as the driven idle, so no false start
    rx_lvl = !cb[17];
    sync_clock_idle_level = cb[10];
    nb = 4'(1 + nd + st);
    e = 13'h0;
    e[0] = cb[17];
    for (k = 0; k < nd; k++) e[k + 1] = w[cb[19] ? nd - 1 - k : k] ^ cb[18] ^ cb[17];
    for (k = 0; k < st; k++) e[1 + nd + k] = !cb[17];
    wr(4'h4, cb);
    wr(4'h0, ca | 32'h9);
    p0 = pulses;
    @(posedge clock_i);
    tx_word_i <= w;
    tx_valid_i <= 1'b1;
    @(posedge clock_i);
    tx_valid_i <= 1'b0;
    // busy is only seen after this edge; done may still hold from the last frame
    @(negedge clock_i);
    for (k = 0; k < 400 && (tx_busy_o !== 1'b0 || !done); k++) @(negedge clock_i);
    chk({19'h0, bits}, {19'h0, e});
    chk(pulses - p0, np);
    chk(swp ? wb : wa, !cb[17]);
    wr(4'h0, 32'h0);
  endtask

  initial begin
    #(25 * 20000);
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rchk(4'h4, ~32'h0, 32'h0);
    rchk(4'h0, ~32'h0, 32'h0);
    wr(4'h4, ~32'h0);
    rchk(4'h4, ~32'h0, 32'h00FF_BF10);
    wr(4'h2, ~32'h0);
    rchk(4'h2, ~32'h0, 32'h0);
    rchk(4'h4, ~32'h0, 32'h00FF_BF10);
    for (int m = 0; m < 4; m++) begin
      wr(4'h4, 32'h0010_0000 | (m << 21));
      rchk(4'h4, ~32'h0, 32'h0010_0000 | (m << 21));
    end
    wr(4'h4, 32'h10);
    repeat (3) @(negedge clock_i);
    chk(naw_o, 1);
    frame(32'h0, 32'h0, 8, 9'h0A5, 0);
    frame(32'h0008_2000, 32'h0000_1000, 9, 9'h14B, 0);
    frame(32'h0006_8000, 32'h1000_0000, 7, 9'h035, 0);
    frame(32'h0000_1F00, 32'h0, 8, 9'h0C3, 8);
    frame(32'h0000_0800, 32'h0, 8, 9'h03C, 7);
    // inverted receive reading makes a high line busy, so no timeout
    wr(4'h4, 32'h0081_0000);
    wr(4'hC, 32'h14);
    wr(4'h0, 32'h0400_0001);
    repeat (60) @(posedge clock_i);
    rchk(4'h8, 32'h1, 32'h0);
    wr(4'h0, 32'h0);
    wr(4'h4, 32'h0080_0000);
    wr(4'h0, 32'h0400_0001);
    repeat (40) @(posedge clock_i);
    rchk(4'h8, 32'h1, 32'h1);
    chk(irq_o, 1);
    wr(4'h0, 32'h1);
    repeat (3) @(negedge clock_i);
    chk(irq_o, 0);
    wr(4'h4, 32'h0);
    wr(4'h8, 32'h1);
    rchk(4'h8, 32'h1, 32'h0);
    stop_test();
  end
endmodule
